/* File: ptl_pkg.sv */
// Package: register map, field positions, reset values and counts
package ptl_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] GEN_CFG_A_OFS   = 8'h00;
    localparam logic [7:0] GEN_CFG_B_OFS   = 8'h04;
    localparam logic [7:0] LOOP_CTRL_OFS   = 8'h08;
    localparam logic [7:0] GOOD_CNT_OFS    = 8'h0c;
    localparam logic [7:0] BAD_CNT_OFS     = 8'h10;
    localparam logic [7:0] GEN_STAT_OFS    = 8'h14;
    localparam logic [7:0] GEN_DA_LO_OFS   = 8'h18;
    localparam logic [7:0] GEN_SA_LO_OFS   = 8'h1c;
    // Config A fields: [15:0] frame size, [23:16] gap, [24] duration
    localparam int SIZE_LSB   = 0;
    localparam int GAP_LSB    = 16;
    localparam int DUR_BIT    = 24;
    // Config B fields
    localparam int ENA_BIT    = 0;
    localparam int RUN_BIT    = 1;
    localparam int BADFCS_BIT = 2;
    localparam int PAT_LSB    = 8;
    // Loop control fields
    localparam int REMOTE_BIT = 0;
    localparam int LOCAL_BIT  = 1;
    localparam int PLUG_BIT   = 2;
    localparam int SWAPOFF_BIT = 3;
    // Reset values
    localparam logic [31:0] CFG_A_RST = 32'h010c_0040;
    localparam logic [31:0] CFG_B_RST = 32'h0000_5a00;
    localparam logic [31:0] LOOP_RST  = 32'h0000_0000;
    // Frame count limit when duration setting is 0
    localparam int unsigned FRAME_LIMIT = 30000000;
    // Speed encodings
    localparam logic [1:0] SPD_10   = 2'h0;
    localparam logic [1:0] SPD_100  = 2'h1;
    localparam logic [1:0] SPD_1000 = 2'h2;
    // Cycles per byte at each speed, 100 MHz clock
    localparam int BYTE_DIV_10   = 80;
    localparam int BYTE_DIV_100  = 8;
    localparam int BYTE_DIV_1000 = 1;
    // Bus data width and FIFO depth
    localparam int DW = 32;
    localparam int FIFO_DEPTH = 4;
endpackage : ptl_pkg

/* File: ptl_fifo.sv */
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module ptl_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    rd_reg;
    logic [AW:0]      cnt_reg;
    logic             push;
    logic             pop;

    // Honest full and empty flags
    assign in_ready  = (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    // Storage write
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + AW'(1);
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + AW'(1);
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    a_fifo_no_overflow : assert property (@(posedge pclk) disable iff (!presetn)
        cnt_reg <= (AW+1)'(DEPTH)) else $error("FIFO overfilled");
endmodule : ptl_fifo

/* File: ptl_crc_counter.sv */
// Saturating frame counter with a clear strobe
`timescale 1ns/1ps
module ptl_crc_counter #(
    parameter int WIDTH = 14
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             inc,
    input  wire logic             clr,
    output logic      [WIDTH-1:0] count
);
    // Count up and hold at the top; a count in the clear cycle survives
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (clr) begin
            count <= inc ? WIDTH'(1) : '0;
        end else if (inc && count != '1) begin
            count <= count + WIDTH'(1);
        end
    end
endmodule : ptl_crc_counter

/* File: ptl_test_top.sv */
// Per-port test logic: frame generator, CRC counters and loopbacks
// Function
// [RULE1] Generator enabled: MAC transmit ignored, generator sole media source.
// [RULE2] Generator works at 10, 100 and 1000 Mbit/s speed settings.
// [RULE3] Writing run to 1 starts frames built from the configuration.
// [RULE4] Duration 0: run clears itself after 30,000,000 frames.
// [RULE5] Operator uses generator only with test equipment, not live networks.
// [RULE6] Readable 14-bit counter of frames received with good CRC.
// [RULE7] Separate readable 8-bit counter of bad CRC frames.
// [RULE8] Remote loopback resends incoming media data back to the partner.
// [RULE9] During remote loopback media data still reaches MAC receive.
// [RULE10] During remote loopback MAC transmit data is disregarded.
// [RULE11] Remote loopback acts only at 1 Gbit/s.
// [RULE12] Local loopback returns MAC transmit data to MAC receive.
// [RULE13] During local loopback nothing goes onto the media.
// [RULE14] Plug loopback needs pairs A-B and C-D joined externally.
// [RULE15] Plug loopback works at every supported speed.
// [RULE16] Software sets negotiation, speed, duplex via registers 0, 4, 9.
// [RULE17] Gigabit plug loopback: enable bit first, then swap correction off.
// [RULE18] Run bit ignored unless generator enable is also set.
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module ptl_test_top #(
    parameter int unsigned FRAME_LIMIT = ptl_pkg::FRAME_LIMIT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  link_speed,
    input  wire logic [7:0]  mac_txd,
    input  wire logic        mac_tx_en,
    input  wire logic [7:0]  media_rxd,
    input  wire logic        media_rx_dv,
    input  wire logic        media_crc_good,
    input  wire logic        media_crc_bad,
    output logic      [7:0]  mac_rxd,
    output logic             mac_rx_dv,
    output logic      [7:0]  media_txd,
    output logic             media_tx_en,
    output logic             pair_swap_off,
    output logic             plug_loop_1000
);
    // Registers
    logic [31:0] cfg_a_reg;
    logic [31:0] cfg_b_reg;
    logic [31:0] loop_reg;
    logic [31:0] da_reg;
    logic [31:0] sa_reg;
    logic [24:0] frames_reg;
    logic [1:0]  spd_reg;
    logic        wr_acc;
    logic        rd_acc;
    logic        good_clr;
    logic        bad_clr;
    logic [13:0] good_cnt;
    logic [7:0]  bad_cnt;

    // Enumerated generator states
    typedef enum logic [3:0] {
        PTL_IDLE = 4'b0001,
        PTL_HEAD = 4'b0010,
        PTL_BODY = 4'b0100,
        PTL_GAP  = 4'b1000
    } ptl_state_t;
    ptl_state_t  st_reg;
    logic [15:0] pos_reg;
    logic [6:0]  div_reg;
    logic        byte_tick;
    logic        gen_go;
    logic        frame_done;

    // FIFO between generator and media
    logic [8:0]  gf_in;
    logic        gf_in_valid;
    logic        gf_in_ready;
    logic [8:0]  gf_out;
    logic        gf_out_valid;
    logic        gf_out_ready;

    logic gen_ena;
    logic gen_run;
    logic remote_on;
    logic local_on;
    assign gen_ena   = cfg_b_reg[ptl_pkg::ENA_BIT];
    assign gen_run   = cfg_b_reg[ptl_pkg::RUN_BIT];
    // [RULE11] Remote gated by speed
    assign remote_on = loop_reg[ptl_pkg::REMOTE_BIT]
                       && (spd_reg == ptl_pkg::SPD_1000);
    assign local_on  = loop_reg[ptl_pkg::LOCAL_BIT];
    // [RULE18] Run needs enable
    assign gen_go    = gen_ena && gen_run;

    // APB strobes; zero-wait answer
    assign wr_acc   = psel && penable && pwrite;
    assign rd_acc   = psel && !penable && !pwrite;
    assign good_clr = wr_acc && paddr == ptl_pkg::GOOD_CNT_OFS;
    assign bad_clr  = wr_acc && paddr == ptl_pkg::BAD_CNT_OFS;

    // Speed setting sampled from the port logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_reg <= ptl_pkg::SPD_10;
        end else begin
            spd_reg <= link_speed;
        end
    end

    // Writable configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_a_reg <= ptl_pkg::CFG_A_RST;
            loop_reg  <= ptl_pkg::LOOP_RST;
            da_reg    <= '1;
            sa_reg    <= 32'h0000_0002;
        end else if (wr_acc) begin
            unique case (paddr)
                ptl_pkg::GEN_CFG_A_OFS: cfg_a_reg <= pwdata;
                // [RULE17] Plug enable and swap-off bits for software
                ptl_pkg::LOOP_CTRL_OFS: loop_reg <= {28'h0, pwdata[3:0]};
                ptl_pkg::GEN_DA_LO_OFS: da_reg <= pwdata;
                ptl_pkg::GEN_SA_LO_OFS: sa_reg <= pwdata;
                default: ;
            endcase
        end
    end

    // Config B with self-clearing run bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_b_reg <= ptl_pkg::CFG_B_RST;
        end else if (wr_acc && paddr == ptl_pkg::GEN_CFG_B_OFS) begin
            cfg_b_reg <= {16'h0, pwdata[15:8], 5'h0, pwdata[2:0]};
        // [RULE4] Auto clear at limit
        end else if (!cfg_a_reg[ptl_pkg::DUR_BIT] && frame_done
                     && frames_reg == 25'(FRAME_LIMIT - 1)) begin
            cfg_b_reg[ptl_pkg::RUN_BIT] <= 1'b0;
        end
    end

    // Frame counter for the duration limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frames_reg <= '0;
        end else if (!gen_go) begin
            frames_reg <= '0;
        end else if (frame_done) begin
            frames_reg <= frames_reg + 25'(1);
        end
    end

    // [RULE2] Byte pacing per speed setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= '0;
        end else if (byte_tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 7'(1);
        end
    end
    always_comb begin
        unique case (spd_reg)
            ptl_pkg::SPD_10:
                byte_tick = div_reg == 7'(ptl_pkg::BYTE_DIV_10 - 1);
            ptl_pkg::SPD_100:
                byte_tick = div_reg == 7'(ptl_pkg::BYTE_DIV_100 - 1);
            default:
                byte_tick = div_reg == 7'(ptl_pkg::BYTE_DIV_1000 - 1);
        endcase
    end

    // Frame builder byte selection
    always_comb begin
        gf_in = {1'b0, cfg_b_reg[15:8]};
        unique case (st_reg)
            PTL_HEAD: begin
                if (pos_reg < 16'd6) begin
                    gf_in = {1'b1, da_reg[8*(pos_reg[1:0])+:8]};
                end else begin
                    gf_in = {1'b1, sa_reg[8*(pos_reg[1:0])+:8]};
                end
            end
            PTL_BODY: begin
                // Corrupted last byte stands for a bad FCS
                if (cfg_b_reg[ptl_pkg::BADFCS_BIT] && pos_reg == 16'd1) begin
                    gf_in = {1'b1, ~cfg_b_reg[15:8]};
                end else begin
                    gf_in = {1'b1, cfg_b_reg[15:8]};
                end
            end
            default: gf_in = {1'b0, cfg_b_reg[15:8]};
        endcase
    end
    assign gf_in_valid = (st_reg == PTL_HEAD || st_reg == PTL_BODY)
                         && byte_tick;
    assign frame_done  = st_reg == PTL_BODY && gf_in_valid && gf_in_ready
                         && pos_reg == 16'd1;

    // [RULE3] Generator sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg  <= PTL_IDLE;
            pos_reg <= '0;
        end else begin
            unique case (st_reg)
                PTL_IDLE: begin
                    if (gen_go) begin
                        st_reg  <= PTL_HEAD;
                        pos_reg <= '0;
                    end
                end
                PTL_HEAD: begin
                    if (gf_in_valid && gf_in_ready) begin
                        if (pos_reg == 16'd11) begin
                            st_reg  <= PTL_BODY;
                            pos_reg <= cfg_a_reg[15:0] - 16'd12;
                        end else begin
                            pos_reg <= pos_reg + 16'd1;
                        end
                    end
                end
                PTL_BODY: begin
                    if (gf_in_valid && gf_in_ready) begin
                        if (pos_reg <= 16'd1) begin
                            st_reg  <= PTL_GAP;
                            pos_reg <= {8'h0, cfg_a_reg[23:16]};
                        end else begin
                            pos_reg <= pos_reg - 16'd1;
                        end
                    end
                end
                PTL_GAP: begin
                    if (byte_tick) begin
                        if (pos_reg == '0) begin
                            st_reg <= gen_go ? PTL_HEAD : PTL_IDLE;
                        end else begin
                            pos_reg <= pos_reg - 16'd1;
                        end
                    end
                end
            endcase
        end
    end

    ptl_fifo #(.WIDTH(9), .DEPTH(ptl_pkg::FIFO_DEPTH)) u_gen_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_data   (gf_in),
        .in_valid  (gf_in_valid),
        .in_ready  (gf_in_ready),
        .out_data  (gf_out),
        .out_valid (gf_out_valid),
        .out_ready (gf_out_ready)
    );
    // Media side drains one byte per byte slot
    assign gf_out_ready = byte_tick;

    // Media transmit path selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            media_txd   <= '0;
            media_tx_en <= 1'b0;
        // [RULE13] Local loop silences media
        end else if (local_on) begin
            media_txd   <= '0;
            media_tx_en <= 1'b0;
        // [RULE1] Generator only source
        end else if (gen_ena) begin
            media_txd   <= gf_out_valid && byte_tick ? gf_out[7:0] : '0;
            media_tx_en <= gf_out_valid && byte_tick && gf_out[8];
        // [RULE8] Echo partner data; [RULE10] MAC ignored
        end else if (remote_on) begin
            media_txd   <= media_rxd;
            media_tx_en <= media_rx_dv;
        end else begin
            media_txd   <= mac_txd;
            media_tx_en <= mac_tx_en;
        end
    end

    // MAC receive path selection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_rxd   <= '0;
            mac_rx_dv <= 1'b0;
        // [RULE12] Transmit looped to receive
        end else if (local_on) begin
            mac_rxd   <= mac_txd;
            mac_rx_dv <= mac_tx_en;
        // [RULE9] Media data still delivered
        end else begin
            mac_rxd   <= media_rxd;
            mac_rx_dv <= media_rx_dv;
        end
    end

    // [RULE15] Plug loopback controls to the analog front end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            plug_loop_1000 <= 1'b0;
            pair_swap_off  <= 1'b0;
        end else begin
            plug_loop_1000 <= loop_reg[ptl_pkg::PLUG_BIT];
            pair_swap_off  <= loop_reg[ptl_pkg::SWAPOFF_BIT];
        end
    end

    // [RULE6] Good CRC counter
    ptl_crc_counter #(.WIDTH(14)) u_good_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (media_crc_good),
        .clr     (good_clr),
        .count   (good_cnt)
    );
    // [RULE7] Bad CRC counter
    ptl_crc_counter #(.WIDTH(8)) u_bad_cnt (
        .pclk    (pclk),
        .presetn (presetn),
        .inc     (media_crc_bad),
        .clr     (bad_clr),
        .count   (bad_cnt)
    );

    // APB read data, registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
            pready  <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr > ptl_pkg::GEN_SA_LO_OFS;
            if (rd_acc) begin
                unique case (paddr)
                    ptl_pkg::GEN_CFG_A_OFS: prdata <= cfg_a_reg;
                    ptl_pkg::GEN_CFG_B_OFS: prdata <= cfg_b_reg;
                    ptl_pkg::LOOP_CTRL_OFS: prdata <= loop_reg;
                    ptl_pkg::GOOD_CNT_OFS:  prdata <= {18'h0, good_cnt};
                    ptl_pkg::BAD_CNT_OFS:   prdata <= {24'h0, bad_cnt};
                    ptl_pkg::GEN_STAT_OFS:
                        prdata <= {3'h0, st_reg, frames_reg};
                    ptl_pkg::GEN_DA_LO_OFS: prdata <= da_reg;
                    ptl_pkg::GEN_SA_LO_OFS: prdata <= sa_reg;
                    default: prdata <= '0;
                endcase
            end
        end
    end

    a_local_quiet : assert property ( // [RULE13]
        @(posedge pclk) disable iff (!presetn) local_on |=> !media_tx_en)
        else $error("Media driven in local loop");
    a_local_echo : assert property ( // [RULE12]
        @(posedge pclk) disable iff (!presetn)
        local_on |=> mac_rxd == $past(mac_txd))
        else $error("Local loop data");
    a_remote_echo : assert property ( // [RULE8]
        @(posedge pclk) disable iff (!presetn)
        remote_on && !local_on && !gen_ena |=> media_txd == $past(media_rxd))
        else $error("Remote loop data");
    a_remote_rx_pass : assert property ( // [RULE9]
        @(posedge pclk) disable iff (!presetn)
        remote_on && !local_on |=> mac_rxd == $past(media_rxd))
        else $error("Receive lost in remote loop");
    // Off gigabit the remote bit leaves the MAC path on the media
    a_remote_speed : assert property ( // [RULE11]
        @(posedge pclk) disable iff (!presetn)
        loop_reg[ptl_pkg::REMOTE_BIT] && spd_reg != ptl_pkg::SPD_1000
        && !local_on && !gen_ena |=> media_txd == $past(mac_txd))
        else $error("Remote loop off gigabit");
    a_gen_only_src : assert property ( // [RULE1]
        @(posedge pclk) disable iff (!presetn)
        gen_ena && !local_on && !gf_out_valid |=> !media_tx_en)
        else $error("MAC data leaked");
    a_run_gate : assert property ( // [RULE18]
        @(posedge pclk) disable iff (!presetn)
        st_reg == PTL_IDLE && !gen_go |=> st_reg == PTL_IDLE)
        else $error("Frames without enable");
    a_run_start : assert property ( // [RULE3]
        @(posedge pclk) disable iff (!presetn)
        st_reg == PTL_IDLE && gen_go |=> st_reg == PTL_HEAD)
        else $error("Run did not start");
    a_good_count : assert property ( // [RULE6]
        @(posedge pclk) disable iff (!presetn)
        media_crc_good && !good_clr && good_cnt != 14'h3fff
        |=> good_cnt == $past(good_cnt) + 14'h1)
        else $error("Good counter missed");
    a_bad_count : assert property ( // [RULE7]
        @(posedge pclk) disable iff (!presetn)
        media_crc_bad && !bad_clr && bad_cnt != 8'hff
        |=> bad_cnt == $past(bad_cnt) + 8'h1)
        else $error("Bad counter missed");
    a_limit_clear : assert property ( // [RULE4]
        @(posedge pclk) disable iff (!presetn)
        frame_done && !cfg_a_reg[ptl_pkg::DUR_BIT] && !wr_acc
        && frames_reg == 25'(FRAME_LIMIT - 1) |=> !gen_run)
        else $error("Run not cleared");
    c_gen_frame : cover property (@(posedge pclk) frame_done);
    c_local_loop : cover property (@(posedge pclk) local_on && mac_tx_en);
    c_remote_loop : cover property (@(posedge pclk) remote_on && media_rx_dv);
    c_fifo_full : cover property (@(posedge pclk) !gf_in_ready);
endmodule : ptl_test_top

/* File: ptl_link_partner.sv */
// Twisted-pair partner model: frame source and loopback plug
`timescale 1ns/1ps
module ptl_link_partner (
    input  wire logic       pclk,
    input  wire logic [7:0] media_txd,
    input  wire logic       media_tx_en,
    input  wire logic       plug_on,
    output logic      [7:0] media_rxd,
    output logic            media_rx_dv,
    output logic            media_crc_good,
    output logic            media_crc_bad
);
    // Quiet line at time zero
    initial begin
        media_rxd = 8'h00;
        media_rx_dv = 1'b0;
        media_crc_good = 1'b0;
        media_crc_bad = 1'b0;
    end
    always @(posedge pclk) begin
        if (plug_on) begin
            media_rxd <= media_tx_en ? media_txd : ~media_rxd;
            media_rx_dv <= media_tx_en;
        end
    end
    task automatic send(input int n, input logic ok);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            media_rxd <= 8'ha5;
            media_rx_dv <= 1'b1;
        end
        @(posedge pclk);
        media_rxd <= 8'h5a;  // Inverse of last byte once released
        media_rx_dv <= 1'b0;
        media_crc_good <= ok;
        media_crc_bad <= !ok;
        @(posedge pclk);
        media_crc_good <= 1'b0;
        media_crc_bad <= 1'b0;
    endtask : send
endmodule : ptl_link_partner

/* File: phy_test_loopback_packet_gen_bench.sv */
// Self-checking bench for the per-port test logic
`timescale 1ns/1ps
module phy_test_loopback_packet_gen_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, mac_txd, media_rxd, mac_rxd, media_txd;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  link_speed;
    logic        mac_tx_en, media_rx_dv, crc_ok, crc_bad, er;
    logic        mac_rx_dv, media_tx_en, swap_off, plug;
    int          err_count = 0, n_compared = 0, seen[5];
    // Clock and stimulus at time zero
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    initial {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    initial {link_speed, mac_txd, mac_tx_en} = '0;
    ptl_test_top #(.FRAME_LIMIT(3)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link_speed(link_speed), .mac_txd(mac_txd),
        .mac_tx_en(mac_tx_en), .media_rxd(media_rxd),
        .media_rx_dv(media_rx_dv), .media_crc_good(crc_ok),
        .media_crc_bad(crc_bad), .mac_rxd(mac_rxd), .mac_rx_dv(mac_rx_dv),
        .media_txd(media_txd), .media_tx_en(media_tx_en),
        .pair_swap_off(swap_off), .plug_loop_1000(plug));
    ptl_link_partner lp (.pclk(pclk), .media_txd(media_txd),
        .media_tx_en(media_tx_en), .plug_on(plug), .media_rxd(media_rxd),
        .media_rx_dv(media_rx_dv), .media_crc_good(crc_ok),
        .media_crc_bad(crc_bad));
    // Byte monitors on the MAC and media sides
    always @(posedge pclk) begin
        if (mac_rx_dv && mac_rxd === 8'ha5) seen[0] <= seen[0] + 1;
        if (mac_rx_dv && mac_rxd === 8'h33) seen[1] <= seen[1] + 1;
        if (media_tx_en && media_txd === 8'h33) seen[2] <= seen[2] + 1;
        if (media_tx_en && media_txd === 8'ha5) seen[3] <= seen[3] + 1;
        if (media_tx_en && media_txd === 8'h5a) seen[4] <= seen[4] + 1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    // One APB transfer; answer taken at the edge that sees pready high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task mac_burst(input int n);
        @(posedge pclk);
        {mac_tx_en, mac_txd} <= {1'b1, 8'h33};
        repeat (n) @(posedge pclk);
        mac_tx_en <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask : mac_burst
    // Let launched bytes pass, then zero the monitors between edges
    task clr_seen;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        seen = '{default: 0};
    endtask : clr_seen
    task t_regs;
        apb(0, ptl_pkg::GEN_CFG_A_OFS, 0); chk(rd, ptl_pkg::CFG_A_RST);
        apb(0, ptl_pkg::GEN_CFG_B_OFS, 0); chk(rd, ptl_pkg::CFG_B_RST);
        apb(0, ptl_pkg::LOOP_CTRL_OFS, 0); chk(rd, ptl_pkg::LOOP_RST);
        apb(1, ptl_pkg::GEN_DA_LO_OFS, 32'h1234_abcd);
        apb(0, ptl_pkg::GEN_DA_LO_OFS, 0); chk(rd, 32'h1234_abcd);
        apb(1, ptl_pkg::GEN_STAT_OFS, 32'hffff_ffff);
        apb(0, ptl_pkg::GEN_STAT_OFS, 0); chk(rd[24:0], 0);
        apb(0, 8'h20, 0); chk(rd, 0); chk(er, 1);
        $display("registers test done");
    endtask : t_regs
    task t_crc;
        lp.send(4, 1);
        lp.send(4, 1);
        lp.send(4, 0);
        apb(0, ptl_pkg::GOOD_CNT_OFS, 0); chk(rd, 2);
        apb(0, ptl_pkg::BAD_CNT_OFS, 0); chk(rd, 1);
        apb(1, ptl_pkg::GOOD_CNT_OFS, 0);
        apb(0, ptl_pkg::GOOD_CNT_OFS, 0); chk(rd, 0);
        $display("crc counter test done");
    endtask : t_crc
    task t_remote(input logic [1:0] spd, input int exp);
        {link_speed, mac_tx_en, mac_txd} <= {spd, 1'b1, 8'h33};
        apb(1, ptl_pkg::LOOP_CTRL_OFS, 32'h1);
        clr_seen;
        lp.send(6, 1);
        repeat (4) @(posedge pclk);
        chk(seen[3], exp);
        chk(seen[0], 6);
        if (exp != 0) chk(seen[2], 0);
        mac_tx_en <= 1'b0;
        apb(1, ptl_pkg::LOOP_CTRL_OFS, 0);
        $display("remote loopback test done");
    endtask : t_remote
    task t_local;
        apb(1, ptl_pkg::LOOP_CTRL_OFS, 32'h2);
        clr_seen;
        mac_burst(5);
        chk(seen[1], 5);
        chk(seen[2], 0);
        apb(1, ptl_pkg::LOOP_CTRL_OFS, 0);
        $display("local loopback test done");
    endtask : t_local
    // Three 13-byte frames, one payload byte each; bad FCS inverts it
    task t_gen(input logic [1:0] spd, input logic bad);
        {link_speed, mac_tx_en, mac_txd} <= {spd, 1'b1, 8'h33};
        apb(1, ptl_pkg::GEN_CFG_A_OFS, 32'h000c_000d);
        apb(1, ptl_pkg::GEN_CFG_B_OFS, 32'h0000_5a02);
        clr_seen;
        repeat (200) @(posedge pclk);
        chk(seen[4], 0);
        apb(1, ptl_pkg::GEN_CFG_B_OFS, {24'h5a, 5'h0, bad, 2'b11});
        clr_seen;
        for (int i = 0; i < 4000; i++) begin
            apb(0, ptl_pkg::GEN_CFG_B_OFS, 0);
            if (rd[1] !== 1'b1) break;
        end
        // Last byte may still wait in the FIFO at low speed
        repeat (200) @(posedge pclk);
        chk(rd, {24'h5a, 5'h0, bad, 2'b01});
        chk(seen[4], bad ? 0 : 3);
        chk(seen[3], bad ? 3 : 0);
        chk(seen[2], 0);
        {mac_tx_en, rd} <= '0;
        apb(1, ptl_pkg::GEN_CFG_B_OFS, 0);
        $display("generator test done");
    endtask : t_gen
    task t_plug(input logic [1:0] spd);
        // Speed set before the plug test
        link_speed <= spd;
        apb(1, ptl_pkg::LOOP_CTRL_OFS, 32'h4);
        repeat (2) @(posedge pclk);
        chk({plug, swap_off}, 2'b10);
        apb(1, ptl_pkg::LOOP_CTRL_OFS, 32'hc);
        repeat (2) @(posedge pclk);
        chk({plug, swap_off}, 2'b11);
        clr_seen;
        mac_burst(5);
        chk(seen[1], 5);
        apb(1, ptl_pkg::LOOP_CTRL_OFS, 0);
        $display("plug loopback test done");
    endtask : t_plug
    // Watchdog cuts a hang short
    initial begin
        #300us;
        err_count++;
        report_and_stop;
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_crc;
        t_remote(ptl_pkg::SPD_1000, 6);
        t_remote(ptl_pkg::SPD_100, 0);
        t_local;
        t_gen(ptl_pkg::SPD_1000, 1'b0);
        t_gen(ptl_pkg::SPD_100, 1'b1);
        t_gen(ptl_pkg::SPD_10, 1'b0);
        t_plug(ptl_pkg::SPD_100);
        t_plug(ptl_pkg::SPD_1000);
        report_and_stop;
    end
endmodule : phy_test_loopback_packet_gen_bench
